// ==== rtl/sai_cfg.svh ====
// Constants of the serial converter output interface
`ifndef SAI_CFG_SVH
`define SAI_CFG_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SAI_PAD_BITS 4'h6
`define SAI_LAST_BIT 4'hF
`define SAI_PAD_VALUE 6'h00
`define SAI_WARM_DONE 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SAI_SYS_NS 10
`define SAI_CONV_NS 600
`define SAI_CONV_CYC ((`SAI_CONV_NS + `SAI_SYS_NS - 1) / `SAI_SYS_NS)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SAI_WORD_RST 10'h000
`define SAI_FRAME_RST 16'h0000
`define SAI_BUSY_RST 7'h00

`endif

// ==== rtl/sai_pkg.sv ====
// Types of the serial converter output interface
package sai_pkg;

   // ----------------------------------------------------------------
   // Data words
   // ----------------------------------------------------------------
   typedef logic [9:0] sai_word_t;
   typedef logic [15:0] sai_frame_t;
   typedef logic [6:0] sai_busy_t;

   typedef struct packed {
      sai_word_t data;
   } sai_smp_t;

   // ----------------------------------------------------------------
   // Link side states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      L_IDLE,
      L_ARM,
      L_SHIFT,
      L_PD
   } sai_lstate_t;

   typedef struct packed {
      sai_lstate_t state;
      logic [3:0] cnt;
      sai_frame_t shreg;
      logic drive;
      logic ack;
      sai_word_t word;
      logic [1:0] warm;
   } sai_link_t;

   typedef struct packed {
      logic req;
      sai_word_t xfer;
      logic samp_prev;
      logic start;
      sai_busy_t busy;
   } sai_sys_t;

   typedef struct packed {
      sai_smp_t mem0;
      sai_smp_t mem1;
      logic wp;
      logic rp;
      logic [1:0] cnt;
   } sai_buf_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } sai_sync_t;

endpackage

// ==== rtl/sai_sync3.sv ====
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module sai_sync3 import sai_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Level
   input wire logic d,
   output logic q
);

   sai_sync_t st_reg;
   sai_sync_t st_next;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      if (st_reg.s2 == st_reg.s3) begin
         st_next.q = st_reg.s3;
      end
      if (!rst_n) begin
         st_next = '0;
      end
   end

   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end

   assign q = st_reg.q;

endmodule // sai_sync3

// ==== rtl/sai_buf2.sv ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sai_buf2 import sai_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire sai_smp_t in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output sai_smp_t out_data
);

   sai_buf_t st_reg;
   sai_buf_t st_next;
   logic push;
   logic pop;

   assign in_ready = (st_reg.cnt != 2'h2);
   assign out_valid = (st_reg.cnt != 2'h0);
   assign out_data = st_reg.rp ? st_reg.mem1 : st_reg.mem0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      if (push) begin
         if (st_reg.wp) begin
            st_next.mem1 = in_data;
         end else begin
            st_next.mem0 = in_data;
         end
         st_next.wp = !st_reg.wp;
      end
      if (pop) begin
         st_next.rp = !st_reg.rp;
      end
      if (push && !pop) begin
         st_next.cnt = st_reg.cnt + 2'h1;
      end else if (pop && !push) begin
         st_next.cnt = st_reg.cnt - 2'h1;
      end
      if (!rst_n) begin
         st_next = '0;
      end
   end

   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end

endmodule // sai_buf2

// ==== rtl/sai_top.sv ====
// Serial result output interface of a 10-bit sampling converter
`timescale 1ns/1ps
`include "sai_cfg.svh"
module sai_top import sai_pkg::*; (
   // System clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Results from the converter core
   input wire logic sample_valid,
   output logic sample_ready,
   input wire sai_word_t sample_data,
   // Conversion status toward the core
   output logic conv_start,
   output logic conv_busy,
   output logic powered_down,
   // Host serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic frame_sync_in,
   output logic data_out,
   output logic data_out_oe
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int unsigned CONV_CYC = `SAI_CONV_CYC;

   sai_sys_t sys_reg;
   sai_sys_t sys_next;
   sai_link_t link_reg;
   sai_link_t link_next;
   logic mode_dsp_reg;
   logic link_clr;
   logic req_sync;
   sai_smp_t smp_in;
   sai_smp_t buf_data;
   logic buf_valid;
   logic buf_ready;
   logic [2:0] to_sys;
   logic [2:0] from_link;
   logic ack_sync;
   logic samp_sync;
   logic pd_sync;
   logic sampling;
   logic link_pd;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic is_pd(input sai_lstate_t s);
      is_pd = (s == L_IDLE) || (s == L_PD);
   endfunction

   function automatic sai_frame_t frame_of(input sai_word_t w);
      frame_of = {`SAI_PAD_VALUE, w};
   endfunction

   // ----------------------------------------------------------------
   // Result buffer
   // ----------------------------------------------------------------
   assign smp_in.data = sample_data;

   sai_buf2 u_buf (
      .clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(smp_in),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_data)
   );

   // ----------------------------------------------------------------
   // Crossings into the system domain
   // ----------------------------------------------------------------
   assign from_link = {link_pd, sampling, link_reg.ack};

   generate
      for (genvar i = 0; i < 3; i++) begin : g_sync
         sai_sync3 u_sync (
            .clk(sys_clk),
            .rst_n(rst_n),
            .d(from_link[i]),
            .q(to_sys[i])
         );
      end
   endgenerate

   assign ack_sync = to_sys[0];
   assign samp_sync = to_sys[1];
   assign pd_sync = to_sys[2];

   // ----------------------------------------------------------------
   // System domain: hand words over, track conversions
   // ----------------------------------------------------------------
   assign buf_ready = !sys_reg.req && !ack_sync;

   always_comb begin
      sys_next = sys_reg;
      sys_next.samp_prev = samp_sync;
      sys_next.start = samp_sync && !sys_reg.samp_prev;
      if (buf_valid && buf_ready) begin
         sys_next.req = 1'b1;
         sys_next.xfer = buf_data.data;
      end else if (sys_reg.req && ack_sync) begin
         sys_next.req = 1'b0;
      end
      if (sys_next.start) begin
         sys_next.busy = sai_busy_t'(CONV_CYC);
      end else if (sys_reg.busy != `SAI_BUSY_RST) begin
         sys_next.busy = sys_reg.busy - 7'h01;
      end
      if (!rst_n) begin
         sys_next = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      sys_reg <= sys_next;
   end

   assign conv_start = sys_reg.start;
   assign conv_busy = (sys_reg.busy != `SAI_BUSY_RST);
   assign powered_down = pd_sync;

   // ----------------------------------------------------------------
   // Mode latch on chip select fall
   // ----------------------------------------------------------------
   // Frame sync low means processor mode
   always_ff @(negedge cs_n) begin
      mode_dsp_reg <= !frame_sync_in;
   end

   // ----------------------------------------------------------------
   // Crossing into the link domain
   // ----------------------------------------------------------------
   sai_sync3 u_req_sync (
      .clk(sclk),
      .rst_n(!link_clr),
      .d(sys_reg.req),
      .q(req_sync)
   );

   // ----------------------------------------------------------------
   // Link domain: framing and shifting on the host clock
   // ----------------------------------------------------------------
   // Select high clears and powers down
   assign link_clr = cs_n || !rst_n;

   always_comb begin
      link_next = link_reg;
      if (link_reg.warm != `SAI_WARM_DONE) begin
         link_next.warm = link_reg.warm + 2'h1;
      end
      if (link_reg.warm == `SAI_WARM_DONE) begin
         if (req_sync && !link_reg.ack) begin
            link_next.word = sys_reg.xfer;
            link_next.ack = 1'b1;
         end else if (!req_sync && link_reg.ack) begin
            link_next.ack = 1'b0;
         end
      end
      case (link_reg.state)
         L_IDLE: begin
            if (!mode_dsp_reg) begin
               // Controller mode starts on first clock
               link_next.state = L_SHIFT;
               link_next.shreg = frame_of(link_reg.word);
               link_next.cnt = 4'h0;
               link_next.drive = 1'b1;
            end else if (frame_sync_in) begin
               link_next.state = L_ARM;
               link_next.drive = 1'b1;
            end
         end
         L_ARM: begin
            if (!frame_sync_in) begin
               link_next.state = L_SHIFT;
               link_next.shreg = frame_of(link_reg.word);
               link_next.cnt = 4'h0;
            end
         end
         L_SHIFT: begin
            if (mode_dsp_reg && frame_sync_in) begin
               link_next.state = L_ARM;
               link_next.shreg = `SAI_FRAME_RST;
            end else if (link_reg.cnt == `SAI_LAST_BIT) begin
               if (mode_dsp_reg) begin
                  link_next.state = L_PD;
                  link_next.drive = 1'b0;
                  link_next.shreg = `SAI_FRAME_RST;
               end else begin
                  link_next.shreg = frame_of(link_reg.word);
                  link_next.cnt = 4'h0;
               end
            end else begin
               link_next.shreg = {link_reg.shreg[14:0], 1'b0};
               link_next.cnt = link_reg.cnt + 4'h1;
            end
         end
         L_PD: begin
            if (frame_sync_in) begin
               link_next.state = L_ARM;
               link_next.drive = 1'b1;
            end
         end
         default: begin
            link_next.state = L_IDLE;
         end
      endcase
   end

   always_ff @(posedge sclk or posedge link_clr) begin
      if (link_clr) begin
         link_reg <= '0;
      end else begin
         link_reg <= link_next;
      end
   end

   assign sampling = (link_reg.state == L_SHIFT) &&
                     (link_reg.cnt < `SAI_PAD_BITS);
   assign link_pd = is_pd(link_reg.state);

   // ----------------------------------------------------------------
   // Data pin
   // ----------------------------------------------------------------
   assign data_out = link_reg.shreg[15];
   assign data_out_oe = !cs_n && (!mode_dsp_reg || link_reg.drive);

endmodule // sai_top

// ==== verification/sai_chk_assertions.sv ====
// Checker of the serial converter output interface
`timescale 1ns/1ps
`include "sai_cfg.svh"
module sai_chk import sai_pkg::*; (
   // System side
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic conv_start,
   input wire logic conv_busy,
   input wire logic powered_down,
   // Host link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic frame_sync_in,
   input wire logic data_out,
   input wire logic data_out_oe
);
   localparam int CONV = `SAI_CONV_CYC;
   logic [7:0] busy_reg;
   logic [4:0] low_reg;
   // --------
   // Helpers
   // --------
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !conv_busy) busy_reg <= 8'h00;
      else busy_reg <= busy_reg + 8'h01;
   end
   always_ff @(posedge sclk or negedge rst_n or posedge cs_n) begin
      if (!rst_n || cs_n) low_reg <= 5'h1F;
      else if (frame_sync_in) low_reg <= 5'h00;
      else if (low_reg != 5'h1F) low_reg <= low_reg + 5'h01;
   end
   // --------
   // Properties
   // --------
   sequence s_arm;
      frame_sync_in ##1 !frame_sync_in;
   endsequence
   property p_float;
      @(posedge sys_clk) disable iff (!rst_n) cs_n |-> !data_out_oe;
   endproperty
   a_float: assert property (p_float)
      else $error("pin driven while deselected");
   property p_pd_idle;
      @(posedge sys_clk) disable iff (!rst_n) cs_n [*8] |-> powered_down;
   endproperty
   a_pd_idle: assert property (p_pd_idle)
      else $error("not powered down while deselected");
   property p_start_busy;
      @(posedge sys_clk) disable iff (!rst_n) conv_start |=> conv_busy;
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("start without busy");
   property p_busy_len;
      @(posedge sys_clk) disable iff (!rst_n)
         $fell(conv_busy) |-> busy_reg == 8'(CONV);
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("conversion length wrong");
   property p_pad;
      @(posedge sclk) disable iff (!rst_n || cs_n)
         s_arm |=> !data_out [*6];
   endproperty
   a_pad: assert property (p_pad)
      else $error("padding bit not zero");
   property p_frame_oe;
      @(posedge sclk) disable iff (!rst_n || cs_n)
         (low_reg >= 5'h01 && low_reg <= 5'h10) |-> data_out_oe;
   endproperty
   a_frame_oe: assert property (p_frame_oe)
      else $error("pin released inside frame");
   property p_auto_pd;
      @(posedge sclk) disable iff (!rst_n || cs_n)
         low_reg == 5'h11 |-> !data_out_oe;
   endproperty
   a_auto_pd: assert property (p_auto_pd)
      else $error("pin driven after last bit");
   property p_mode_dsp;
      @(posedge sys_clk) disable iff (!rst_n)
         $fell(cs_n) && !frame_sync_in |-> !data_out_oe [*4];
   endproperty
   a_mode_dsp: assert property (p_mode_dsp)
      else $error("processor mode drives before sync");
   property p_mode_ctl;
      @(posedge sys_clk) disable iff (!rst_n)
         $fell(cs_n) && frame_sync_in |-> ##[0:2] data_out_oe;
   endproperty
   a_mode_ctl: assert property (p_mode_ctl)
      else $error("controller mode not driving");
endmodule // sai_chk

bind sai_top sai_chk u_chk (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .conv_start(conv_start),
   .conv_busy(conv_busy),
   .powered_down(powered_down),
   .sclk(sclk),
   .cs_n(cs_n),
   .frame_sync_in(frame_sync_in),
   .data_out(data_out),
   .data_out_oe(data_out_oe)
);

// ==== verification/sai_host.sv ====
// Host model driving the serial link
`timescale 1ns/1ps
module sai_host import sai_pkg::*; (
   // Host lines
   output logic sclk,
   output logic cs_n,
   output logic frame_sync_in,
   // Device answer
   input wire logic data_out,
   input wire logic data_out_oe
);
   sai_frame_t rx;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      frame_sync_in = 1'b1;
      rx = 16'h0000;
   end
   // --------
   // Link tasks
   // --------
   // sync level at select
   task automatic select(input logic ctl);
      frame_sync_in = ctl;
      #40 cs_n = 1'b0;
      #40;
   endtask
   task automatic deselect();
      #40 cs_n = 1'b1;
      #40;
   endtask
   task automatic tick(input logic fs);
      frame_sync_in = fs;
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
      rx = {rx[14:0], data_out};
   endtask
endmodule // sai_host

// ==== verification/test_serial_adc_output_interface.sv ====
// Testbench of the serial converter output interface
`timescale 1ns/1ps
module test_serial_adc_output_interface import sai_pkg::*;;
   logic sys_clk, rst_n, sample_valid, sample_ready;
   sai_word_t sample_data;
   logic conv_start, conv_busy, powered_down;
   logic sclk, cs_n, frame_sync_in, data_out, data_out_oe;
   int num_errors, checks_done, starts;
   sai_top dut (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .sample_valid(sample_valid),
      .sample_ready(sample_ready),
      .sample_data(sample_data),
      .conv_start(conv_start),
      .conv_busy(conv_busy),
      .powered_down(powered_down),
      .sclk(sclk),
      .cs_n(cs_n),
      .frame_sync_in(frame_sync_in),
      .data_out(data_out),
      .data_out_oe(data_out_oe)
   );
   sai_host host (
      .sclk(sclk),
      .cs_n(cs_n),
      .frame_sync_in(frame_sync_in),
      .data_out(data_out),
      .data_out_oe(data_out_oe)
   );
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (conv_start === 1'b1) starts++;
   // --------
   // Helpers
   // --------
   task automatic end_sim();
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_word(input sai_frame_t got, input sai_frame_t exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic push(input sai_word_t w, output logic taken);
      @(posedge sys_clk);
      #1 sample_valid = 1'b1;
      sample_data = w;
      taken = (sample_ready === 1'b1);
      @(posedge sys_clk);
      #1 sample_valid = 1'b0;
   endtask
   task automatic wait_pd();
      for (int i = 0; i < 30 && powered_down !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      check_bit(powered_down, 1'b1);
   endtask
   task automatic proc_frame(input sai_frame_t exp);
      int s0;
      s0 = starts;
      host.tick(1'b1);
      check_bit(data_out_oe, 1'b1);
      repeat (16) host.tick(1'b0);
      check_word(host.rx, exp);
      repeat (2) host.tick(1'b0);
      check_bit(data_out_oe, 1'b0);
      check_bit(starts > s0, 1'b1);
      wait_pd();
   endtask
   // --------
   // Scenarios
   // --------
   task automatic t_fill_drain();
      logic tk;
      int n;
      n = 0;
      for (int i = 1; i <= 4; i++) begin
         push(10'h300 + 10'(i), tk);
         if (tk) n++;
      end
      check_word(16'(n), 16'h0003);
      host.select(1'b0);
      check_bit(data_out_oe, 1'b0);
      repeat (40) host.tick(1'b0);
      check_bit(sample_ready, 1'b1);
      proc_frame(16'h0303);
   endtask
   task automatic t_abort();
      logic tk;
      push(10'h2A5, tk);
      repeat (8) host.tick(1'b0);
      host.tick(1'b1);
      repeat (8) host.tick(1'b0);
      proc_frame(16'h02A5);
   endtask
   task automatic t_ctrl();
      logic tk;
      host.deselect();
      wait_pd();
      check_bit(data_out_oe, 1'b0);
      push(10'h15A, tk);
      host.select(1'b1);
      check_bit(data_out_oe, 1'b1);
      repeat (32) host.tick(1'b1);
      check_word(host.rx, 16'h015A);
      host.deselect();
      check_bit(data_out_oe, 1'b0);
   endtask
   initial begin
      rst_n = 1'b0;
      sample_valid = 1'b0;
      sample_data = 10'h000;
      num_errors = 0;
      checks_done = 0;
      starts = 0;
      repeat (16) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      wait_pd();
      check_bit(data_out_oe, 1'b0);
      t_fill_drain();
      t_abort();
      t_ctrl();
      end_sim();
   end
   initial begin
      #500000;
      num_errors++;
      end_sim();
   end
endmodule // test_serial_adc_output_interface
